// >>> verilog/dog_pkg.sv
// package: watchdog constants, timeout table and mode type
package dog_pkg;

	// ************************************************************
	// widths and reset values
	// ************************************************************
	localparam int         COUNT_W              = 20;
	localparam int         OSC_FREQ_KHZ         = 128;
	localparam int         SHORTEST_TIMEOUT_MS  = 1;
	localparam int         LONGEST_TIMEOUT_S    = 8;
	localparam logic [2:0] UNLOCK_CYCLES        = 3'h4;
	localparam logic [2:0] UNLOCK_IDLE          = 3'h0;
	localparam logic [3:0] TIMEOUT_SELECT_RESET = 4'h0;
	localparam logic [2:0] BROWNOUT_OFF_CODE    = 3'h7;

	// ************************************************************
	// terminal counts (oscillator cycles minus one)
	// ************************************************************
	localparam logic [COUNT_W-1:0] TC_2K    = 20'h007ff;
	localparam logic [COUNT_W-1:0] TC_4K    = 20'h00fff;
	localparam logic [COUNT_W-1:0] TC_8K    = 20'h01fff;
	localparam logic [COUNT_W-1:0] TC_16K   = 20'h03fff;
	localparam logic [COUNT_W-1:0] TC_32K   = 20'h07fff;
	localparam logic [COUNT_W-1:0] TC_64K   = 20'h0ffff;
	localparam logic [COUNT_W-1:0] TC_128K  = 20'h1ffff;
	localparam logic [COUNT_W-1:0] TC_256K  = 20'h3ffff;
	localparam logic [COUNT_W-1:0] TC_512K  = 20'h7ffff;
	localparam logic [COUNT_W-1:0] TC_1024K = 20'hfffff;
	localparam logic [COUNT_W-1:0] TC_1K    = 20'h003ff;
	localparam logic [COUNT_W-1:0] TC_512   = 20'h001ff;
	localparam logic [COUNT_W-1:0] TC_256   = 20'h000ff;
	localparam logic [COUNT_W-1:0] TC_128   = 20'h0007f;

	// ************************************************************
	// operating modes
	// ************************************************************
	typedef enum logic [3:0] {
		MODE_STOPPED  = 4'h1,
		MODE_IRQ      = 4'h2,
		MODE_RESET    = 4'h4,
		MODE_COMBINED = 4'h8
	} dog_mode_t;

endpackage : dog_pkg

// >>> verilog/dog_timeout_decode.sv
// module: timeout_select to terminal count decoder
module dog_timeout_decode (
	// selection
	input  wire logic [3:0]                  timeout_select,
	// decoded count
	output logic      [dog_pkg::COUNT_W-1:0] terminal_count
);
	import dog_pkg::*;

	// ************************************************************
	// decode
	// ************************************************************
	always_comb begin
		case (timeout_select)
			4'h0:    terminal_count = TC_2K;
			4'h1:    terminal_count = TC_4K;
			4'h2:    terminal_count = TC_8K;
			4'h3:    terminal_count = TC_16K;
			4'h4:    terminal_count = TC_32K;
			4'h5:    terminal_count = TC_64K;
			4'h6:    terminal_count = TC_128K;
			4'h7:    terminal_count = TC_256K;
			4'h8:    terminal_count = TC_512K;
			4'h9:    terminal_count = TC_1024K;
			4'ha:    terminal_count = TC_1K;
			4'hb:    terminal_count = TC_512;
			4'hc:    terminal_count = TC_256;
			4'hd:    terminal_count = TC_128;
			default: terminal_count = TC_1024K;
		endcase
	end

endmodule : dog_timeout_decode

// >>> verilog/ref_power_enable.sv
// module: bandgap and internal reference power enable
module ref_power_enable (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       reset,
	// reference users
	input  wire logic [2:0] brownout_level_fuse,
	input  wire logic       ref_select_hi,
	input  wire logic       comparator_bandgap_sel,
	input  wire logic       adc_enable,
	// power control
	output logic            bandgap_enable
);
	import dog_pkg::*;

	logic need_ref;

	// ************************************************************
	// enable
	// ************************************************************
	assign need_ref = (brownout_level_fuse != BROWNOUT_OFF_CODE) | ref_select_hi |
	                  comparator_bandgap_sel | adc_enable;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			bandgap_enable <= 1'b0;
		end else begin
			bandgap_enable <= need_ref;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	chk_ref_follows: assert property (@(posedge ref_clk) disable iff (reset)
		need_ref |=> bandgap_enable)
		else $error("reference not powered while a user needs it");
	chk_ref_off: assert property (@(posedge ref_clk) disable iff (reset)
		!need_ref |=> !bandgap_enable)
		else $error("reference powered with no user");

endmodule : ref_power_enable

// >>> verilog/watchdog_timer_with_ref_enable.sv
// module: watchdog timer with timed unlock and reference enable
//
// Contract
// - counter advances on each 128 kHz oscillator tick, held at zero while stopped
// - restart zeroes counter, else time-out acts
// - interrupt mode requests irq, able to wake
// - reset mode asserts system reset at time-out
// - combined mode: irq first, then reset
// - fuse forces reset on, irq enable off
// - four-cycle window accepts reset_enable and select
// - watchdog stays enabled after its own reset
// - time-outs from about 1 ms to 8 s
// - reference powered whenever any user needs it
// - cause flag holds reset_enable_bit at one
// - change_unlock_bit self-clears after four cycles
// - four-bit select decodes 128 to 1048576 cycles
// - vector clears flag, and irq enable only while reset_enable_bit is set
module watchdog_timer_with_ref_enable (
	// clock and reset
	input  wire logic                         ref_clk,
	input  wire logic                         reset,
	// oscillator and core events
	input  wire logic                         osc_tick,
	input  wire logic                         restart_pulse,
	input  wire logic                         vector_ack,
	input  wire logic                         always_on_fuse,
	// control register write
	input  wire logic                         wr_strobe,
	input  wire logic                         wr_irq_flag_clear,
	input  wire logic                         wr_irq_enable,
	input  wire logic                         wr_change_unlock,
	input  wire logic                         wr_reset_enable,
	input  wire logic [3:0]                   wr_timeout_select,
	// reset cause
	input  wire logic                         cause_flag_clear,
	// reference users
	input  wire logic [2:0]                   brownout_level_fuse,
	input  wire logic                         ref_select_hi,
	input  wire logic                         comparator_bandgap_sel,
	input  wire logic                         adc_enable,
	// status
	output logic                              reset_enable_bit,
	output logic                              irq_enable_bit,
	output logic                              change_unlock_bit,
	output logic      [3:0]                   timeout_select,
	output logic                              dog_irq_flag,
	output logic                              dog_reset_cause_flag,
	output logic      [dog_pkg::COUNT_W-1:0]  dog_counter,
	// actions
	output logic                              dog_irq_request,
	output logic                              system_reset_out,
	output logic                              bandgap_enable
);
	import dog_pkg::*;

	// ************************************************************
	// declarations
	// ************************************************************
	logic [COUNT_W-1:0] terminal_count;
	logic [2:0]         unlock_cnt_reg;
	logic [2:0]         unlock_cnt_next;
	dog_mode_t          mode;
	logic               window_open;
	logic               unlock_start;
	logic               window_write;
	logic               running;
	logic               timeout_hit;
	logic               irq_set;
	logic               fire_reset;

	// ************************************************************
	// sub-blocks
	// ************************************************************
	dog_timeout_decode u_decode (
		.timeout_select (timeout_select),
		.terminal_count (terminal_count)
	);

	ref_power_enable u_ref (
		.ref_clk                (ref_clk),
		.reset                  (reset),
		.brownout_level_fuse    (brownout_level_fuse),
		.ref_select_hi          (ref_select_hi),
		.comparator_bandgap_sel (comparator_bandgap_sel),
		.adc_enable             (adc_enable),
		.bandgap_enable         (bandgap_enable)
	);

	// ************************************************************
	// mode selection
	// ************************************************************
	always_comb begin
		if (always_on_fuse) begin
			mode = MODE_RESET;
		end else if (reset_enable_bit && irq_enable_bit) begin
			mode = MODE_COMBINED;
		end else if (reset_enable_bit) begin
			mode = MODE_RESET;
		end else if (irq_enable_bit) begin
			mode = MODE_IRQ;
		end else begin
			mode = MODE_STOPPED;
		end
	end

	assign running     = (mode != MODE_STOPPED);
	assign timeout_hit = running && osc_tick && !restart_pulse && (dog_counter == terminal_count);

	// ************************************************************
	// time-out action
	// ************************************************************
	always_comb begin
		irq_set    = 1'b0;
		fire_reset = 1'b0;
		case (mode)
			MODE_IRQ: begin
				irq_set = timeout_hit;
			end
			MODE_RESET: begin
				fire_reset = timeout_hit;
			end
			MODE_COMBINED: begin
				if (dog_irq_flag) begin
					fire_reset = timeout_hit;
				end else begin
					irq_set = timeout_hit;
				end
			end
			default: begin
				irq_set    = 1'b0;
				fire_reset = 1'b0;
			end
		endcase
	end

	// ************************************************************
	// watchdog counter
	// ************************************************************
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			dog_counter <= '0;
		end else if (restart_pulse || timeout_hit || !running) begin
			dog_counter <= '0;
		end else if (osc_tick) begin
			dog_counter <= dog_counter + 20'h00001;
		end
	end

	// ************************************************************
	// system reset pulse and cause flag
	// ************************************************************
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			system_reset_out <= 1'b0;
		end else begin
			system_reset_out <= fire_reset;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			dog_reset_cause_flag <= 1'b0;
		end else if (fire_reset) begin
			dog_reset_cause_flag <= 1'b1;
		end else if (cause_flag_clear) begin
			dog_reset_cause_flag <= 1'b0;
		end
	end

	// ************************************************************
	// timed unlock sequence
	// ************************************************************
	assign unlock_start = wr_strobe && wr_change_unlock && wr_reset_enable;
	assign window_open  = (unlock_cnt_reg != UNLOCK_IDLE);
	assign window_write = wr_strobe && window_open && !wr_change_unlock;

	always_comb begin
		if (unlock_start) begin
			unlock_cnt_next = UNLOCK_CYCLES;
		end else if (window_write || !window_open) begin
			unlock_cnt_next = UNLOCK_IDLE;
		end else begin
			unlock_cnt_next = unlock_cnt_reg - 3'h1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			unlock_cnt_reg <= UNLOCK_IDLE;
		end else begin
			unlock_cnt_reg <= unlock_cnt_next;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			change_unlock_bit <= 1'b0;
		end else begin
			change_unlock_bit <= (unlock_cnt_next != UNLOCK_IDLE);
		end
	end

	// ************************************************************
	// reset enable
	// ************************************************************
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			reset_enable_bit <= 1'b0;
		end else if (always_on_fuse || dog_reset_cause_flag || fire_reset) begin
			reset_enable_bit <= 1'b1;
		end else if (window_write) begin
			reset_enable_bit <= wr_reset_enable;
		end else if (wr_strobe && wr_reset_enable) begin
			reset_enable_bit <= 1'b1;
		end
	end

	// ************************************************************
	// timeout select
	// ************************************************************
	always_ff @(posedge ref_clk) begin
		if (reset || fire_reset) begin
			timeout_select <= TIMEOUT_SELECT_RESET;
		end else if (window_write) begin
			timeout_select <= wr_timeout_select;
		end
	end

	// ************************************************************
	// interrupt enable and flag
	// ************************************************************
	always_ff @(posedge ref_clk) begin
		if (reset || always_on_fuse || fire_reset) begin
			irq_enable_bit <= 1'b0;
		end else if (wr_strobe && wr_irq_enable) begin
			irq_enable_bit <= 1'b1;
		end else if (vector_ack && reset_enable_bit) begin
			irq_enable_bit <= 1'b0;
		end else if (wr_strobe) begin
			irq_enable_bit <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset || fire_reset) begin
			dog_irq_flag <= 1'b0;
		end else if (irq_set) begin
			dog_irq_flag <= 1'b1;
		end else if (vector_ack || (wr_strobe && wr_irq_flag_clear)) begin
			dog_irq_flag <= 1'b0;
		end
	end

	// level request, needs no clock to reach the wake logic
	assign dog_irq_request = dog_irq_flag && irq_enable_bit;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	sequence s_unlock_write;
		wr_strobe && wr_change_unlock && wr_reset_enable;
	endsequence

	sequence s_quiet_window;
		(change_unlock_bit && !wr_strobe) [*4];
	endsequence

	chk_unlock_opens: assert property (s_unlock_write |=> change_unlock_bit)
		else $error("unlock write did not open the window");
	chk_unlock_closes: assert property (s_quiet_window |=> !change_unlock_bit)
		else $error("unlock window lasted beyond four cycles");
	chk_restart_zero: assert property (restart_pulse |=> dog_counter == '0)
		else $error("restart did not zero the counter");
	chk_timeout_wrap: assert property (timeout_hit |=> dog_counter == '0)
		else $error("counter not restarted after time-out");
	chk_fuse_lock: assert property (always_on_fuse [*2] |-> reset_enable_bit && !irq_enable_bit)
		else $error("fuse did not lock the mode bits");
	chk_cause_holds: assert property (dog_reset_cause_flag |-> reset_enable_bit)
		else $error("reset enable dropped while cause flag set");
	chk_reset_fire: assert property ((mode == MODE_RESET) && timeout_hit
		|=> system_reset_out && dog_reset_cause_flag ##1 !system_reset_out)
		else $error("reset mode time-out gave no one-cycle reset");
	chk_irq_mode: assert property ((mode == MODE_IRQ) && timeout_hit |=> dog_irq_flag && !system_reset_out)
		else $error("interrupt mode time-out mishandled");
	chk_combined_second: assert property ((mode == MODE_COMBINED) && dog_irq_flag && timeout_hit
		|=> system_reset_out)
		else $error("second combined time-out gave no reset");
	chk_combined_first: assert property ((mode == MODE_COMBINED) && !dog_irq_flag && timeout_hit
		|=> dog_irq_flag && !system_reset_out)
		else $error("first combined time-out was not an interrupt");
	chk_count_step: assert property (running && osc_tick && !restart_pulse && !timeout_hit
		|=> dog_counter == $past(dog_counter) + 20'h00001)
		else $error("counter did not advance on an oscillator tick");
	chk_locked_select: assert property (wr_strobe && !window_open && !fire_reset
		|=> timeout_select == $past(timeout_select))
		else $error("timeout select changed outside the window");
	chk_vector_clear: assert property ((mode == MODE_COMBINED) && vector_ack && !irq_set && !wr_strobe
		|=> !irq_enable_bit && !dog_irq_flag)
		else $error("vector did not clear enable and flag");

endmodule : watchdog_timer_with_ref_enable

// >>> bench/core_model.sv
// partner: core issuing restart, vector, cause clear and control writes
module core_model (
	// clock
	input  wire logic ref_clk,
	// core events
	output logic       restart_pulse,
	output logic       vector_ack,
	output logic       cause_flag_clear,
	// control write
	output logic       wr_strobe,
	output logic       wr_irq_flag_clear,
	output logic       wr_irq_enable,
	output logic       wr_change_unlock,
	output logic       wr_reset_enable,
	output logic [3:0] wr_timeout_select
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		{restart_pulse, vector_ack, cause_flag_clear, wr_strobe} = 4'h0;
		{wr_irq_flag_clear, wr_irq_enable, wr_change_unlock, wr_reset_enable} = 4'h0;
		wr_timeout_select = 4'h0;
	end

	// one-cycle event: 0 restart, 1 vector, 2 cause clear
	task pulse_evt(input int which);
		@(posedge ref_clk);
		restart_pulse <= (which == 0);
		vector_ack <= (which == 1);
		cause_flag_clear <= (which == 2);
		@(posedge ref_clk);
		{restart_pulse, vector_ack, cause_flag_clear} <= 3'h0;
	endtask : pulse_evt

	// one control write, fields inverted once released
	task write_ctrl(input logic fc, input logic ie, input logic un, input logic re, input logic [3:0] sel);
		@(posedge ref_clk);
		wr_strobe <= 1'b1;
		{wr_irq_flag_clear, wr_irq_enable, wr_change_unlock, wr_reset_enable} <= {fc, ie, un, re};
		wr_timeout_select <= sel;
		@(posedge ref_clk);
		wr_strobe <= 1'b0;
		{wr_irq_flag_clear, wr_irq_enable, wr_change_unlock, wr_reset_enable} <= ~{fc, ie, un, re};
		wr_timeout_select <= ~sel;
	endtask : write_ctrl

	// timed setup change
	task set_mode(input logic ie, input logic re, input logic [3:0] sel);
		pulse_evt(0);
		write_ctrl(1'b0, ie, 1'b1, 1'b1, sel);
		write_ctrl(1'b0, ie, 1'b0, re, sel);
	endtask : set_mode
endmodule : core_model

// >>> bench/watchdog_timer_with_ref_enable_test.sv
// bench: self-checking test of the watchdog block
module watchdog_timer_with_ref_enable_test;
	timeunit 1ns;
	timeprecision 1ns;
	import dog_pkg::*;

	logic ref_clk, reset, osc_tick, tick_on, fuse, sel_hi, cmp_bg, adc_en;
	logic [2:0] bl_fuse;
	logic restart_pulse, vector_ack, cause_clr, wr_strobe, wr_fc, wr_ie, wr_un, wr_re;
	logic [3:0] wr_sel, timeout_select;
	logic re_bit, ie_bit, cub, irq_flag, cause, irq_req, rst_out, bg_en;
	logic [COUNT_W-1:0] dog_counter;
	int n_fail = 0, checks = 0, cyc = 0;

	core_model u_core_model (.ref_clk(ref_clk), .restart_pulse(restart_pulse), .vector_ack(vector_ack),
		.cause_flag_clear(cause_clr), .wr_strobe(wr_strobe), .wr_irq_flag_clear(wr_fc),
		.wr_irq_enable(wr_ie), .wr_change_unlock(wr_un), .wr_reset_enable(wr_re),
		.wr_timeout_select(wr_sel));

	watchdog_timer_with_ref_enable u_watchdog_timer_with_ref_enable (.ref_clk(ref_clk), .reset(reset),
		.osc_tick(osc_tick), .restart_pulse(restart_pulse), .vector_ack(vector_ack),
		.always_on_fuse(fuse), .wr_strobe(wr_strobe), .wr_irq_flag_clear(wr_fc), .wr_irq_enable(wr_ie),
		.wr_change_unlock(wr_un), .wr_reset_enable(wr_re), .wr_timeout_select(wr_sel),
		.cause_flag_clear(cause_clr), .brownout_level_fuse(bl_fuse), .ref_select_hi(sel_hi),
		.comparator_bandgap_sel(cmp_bg), .adc_enable(adc_en), .reset_enable_bit(re_bit),
		.irq_enable_bit(ie_bit), .change_unlock_bit(cub), .timeout_select(timeout_select),
		.dog_irq_flag(irq_flag), .dog_reset_cause_flag(cause), .dog_counter(dog_counter),
		.dog_irq_request(irq_req), .system_reset_out(rst_out), .bandgap_enable(bg_en));

	// ************************************************************
	// clock, oscillator tick, run limit
	// ************************************************************
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		osc_tick <= tick_on;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			complete_run();
		end
	end

	task check(input string name, input logic [19:0] seen, input logic [19:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// level pins, driven just after an edge
	task set_pins(input logic f, input logic [5:0] users);
		fuse <= f;
		{bl_fuse, sel_hi, cmp_bg, adc_en} <= users;
	endtask : set_pins

	task complete_run();
		if (n_fail == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run

	// cycles until reset pulse (rst=1) or irq flag
	task wait_evt(input bit rst, output int n);
		n = 0;
		while (((rst ? rst_out : irq_flag) !== 1'b1) && n < 3000) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
	endtask : wait_evt

	function automatic logic [19:0] near128(input int n);
		return {19'h0, (n >= 120 && n <= 136)};
	endfunction : near128

	// ************************************************************
	// scenarios
	// ************************************************************
	task t_after_reset();
		check("idle flags", {re_bit, ie_bit, cub, irq_flag, cause, rst_out, bg_en}, 20'h0);
		check("select", timeout_select, 20'h0);
		check("counter", dog_counter, 20'h0);
	endtask : t_after_reset

	task t_unlock_expiry();
		int k;
		k = 0;
		u_core_model.write_ctrl(1'b0, 1'b0, 1'b1, 1'b1, 4'h0);
		repeat (8) begin
			#1;
			if (cub === 1'b1)
				k++;
			@(posedge ref_clk);
		end
		check("unlock cycles", k, 20'h4);
	endtask : t_unlock_expiry

	task t_reset_mode();
		int n;
		u_core_model.set_mode(1'b0, 1'b1, 4'hd);
		#1 check("select set", timeout_select, 20'hd);
		u_core_model.write_ctrl(1'b0, 1'b0, 1'b0, 1'b0, 4'h3);
		#1 check("locked write", {re_bit, timeout_select}, 20'h1d);
		tick_on = 1'b1;
		u_core_model.pulse_evt(0);
		wait_evt(1'b1, n);
		check("reset delay", near128(n), 20'h1);
		check("cause set", {cause, re_bit}, 20'h3);
		@(posedge ref_clk);
		#1 check("reset pulse width", rst_out, 20'h0);
		check("count restarted", {19'h0, dog_counter < 20'h8}, 20'h1);
		u_core_model.set_mode(1'b0, 1'b0, 4'hd);
		#1 check("held by cause", re_bit, 20'h1);
		u_core_model.pulse_evt(2);
		u_core_model.set_mode(1'b0, 1'b0, 4'hd);
		#1 check("enable cleared", {cause, re_bit}, 20'h0);
	endtask : t_reset_mode

	task t_irq_mode();
		int n;
		logic [19:0] held;
		u_core_model.set_mode(1'b1, 1'b0, 4'hd);
		repeat (4) begin
			u_core_model.pulse_evt(0);
			repeat (100) @(posedge ref_clk);
		end
		#1 check("restarted in time", irq_flag, 20'h0);
		tick_on = 1'b0;
		repeat (3) @(posedge ref_clk);
		#1 held = dog_counter;
		repeat (20) @(posedge ref_clk);
		#1 check("no tick no count", dog_counter, held);
		tick_on = 1'b1;
		u_core_model.pulse_evt(0);
		wait_evt(1'b0, n);
		check("irq delay", near128(n), 20'h1);
		check("irq request", {irq_req, cause}, 20'h2);
		u_core_model.write_ctrl(1'b1, 1'b1, 1'b0, 1'b0, 4'hd);
		#1 check("flag cleared", irq_flag, 20'h0);
	endtask : t_irq_mode

	task t_combined();
		int n;
		u_core_model.set_mode(1'b1, 1'b1, 4'hd);
		wait_evt(1'b0, n);
		check("first is irq", {irq_req, cause}, 20'h2);
		wait_evt(1'b1, n);
		check("then reset", near128(n), 20'h1);
		u_core_model.pulse_evt(2);
		u_core_model.set_mode(1'b1, 1'b1, 4'hd);
		wait_evt(1'b0, n);
		u_core_model.pulse_evt(1);
		#1 check("vector clears", {ie_bit, irq_flag, re_bit}, 20'h1);
	endtask : t_combined

	task t_fuse();
		@(posedge ref_clk);
		set_pins(1'b1, {BROWNOUT_OFF_CODE, 3'h0});
		repeat (2) @(posedge ref_clk);
		u_core_model.set_mode(1'b1, 1'b0, 4'hd);
		#1 check("fuse forces", {re_bit, ie_bit}, 20'h2);
		@(posedge ref_clk);
		set_pins(1'b0, {BROWNOUT_OFF_CODE, 3'h0});
	endtask : t_fuse

	task t_reference();
		logic [5:0] tbl [5];
		tbl = '{6'h38, 6'h3c, 6'h3a, 6'h39, 6'h00};
		for (int i = 0; i < 5; i++) begin
			@(posedge ref_clk);
			set_pins(1'b0, tbl[i]);
			repeat (3) @(posedge ref_clk);
			#1 check("bandgap", bg_en, {19'h0, i != 0});
		end
	endtask : t_reference

	initial begin
		reset <= 1'b1;
		tick_on <= 1'b0;
		set_pins(1'b0, {BROWNOUT_OFF_CODE, 3'h0});
		repeat (8) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		#1 t_after_reset();
		t_unlock_expiry();
		t_reset_mode();
		t_irq_mode();
		t_combined();
		t_fuse();
		t_reference();
		complete_run();
	end
endmodule : watchdog_timer_with_ref_enable_test
